/* verilog/psc_pkg.sv */
// Constants for the sleep/configuration host controller of an async PSRAM.
// Assumes a 20 MHz system clock and a device driven only through its pins.
// Contract
// R1: Reserved configuration bits 21:8 and 3 are always written as zero.
// R2: Bit 7 enables page-mode reads; power-up default disabled.
// R3: Bits 6:5 pick refresh temperature level; 11 highest is default.
// R4: Bit 4 picks sleep mode: 1 partial refresh, 0 deep sleep.
// R5: Bits 2:0 refresh extent: 000 full array, 100 none.
// R6: Other extent codes count as full-array refresh.
// R7: Sleep pin low enters the mode chosen by bit 4.
// R8: After a software-sequence write, sleep pin no longer starts partial refresh.
// R9: Deep sleep is set or cleared only through a pin-triggered load.
// R10: Deep sleep stops refresh; stored data is then invalid.
// R11: No normal access for 150 us after leaving deep sleep.
// R12: Temperature level must be at or above case temperature.
// R13: Configuration word powers up as 0070h.
// R14: Write after sleep-pin fall loads address bits 21:0 into the word.
// R15: Software sequence: two reads, two writes at top address, data 15:0.
// R16: Low-power mode needs sleep pin low over 10 us; accesses ignored.
// R17: With page mode off every read is a full random access.
// R18: A pin-triggered load updates all fields together.
package psc_pkg;
    localparam int          ADDR_W       = 22;
    localparam int          DATA_W       = 16;
    localparam logic [21:0] TOP_ADDR     = 22'h3fffff;
    localparam logic [21:0] CFG_RESET    = 22'h000070;
    localparam logic [21:0] CFG_WR_MASK  = 22'h0000f7;
    localparam int          CFG_PAGE_BIT = 7;
    localparam int          CFG_TEMP_LSB = 5;
    localparam int          CFG_SLEEP_BIT = 4;
    localparam int          CFG_EXT_LSB  = 0;
    localparam logic [2:0]  EXT_FULL     = 3'h0;
    localparam logic [2:0]  EXT_NONE     = 3'h4;
    // Host register map
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_CFG      = 4'h1;
    localparam logic [3:0]  REG_STATUS   = 4'h2;
    localparam logic [3:0]  REG_RDBACK   = 4'h3;
    localparam int          CTRL_SLEEP   = 0;
    localparam int          CTRL_PINLOAD = 1;
    localparam int          CTRL_SWLOAD  = 2;
    localparam int          CTRL_SWREAD  = 3;
    // Timing
    localparam int          CLK_MHZ      = 20;
    localparam int          SLEEP_MIN_US = 10;
    localparam int          INIT_US      = 150;
    localparam int          SLEEP_CYC    = SLEEP_MIN_US * CLK_MHZ + 1;
    localparam int          INIT_CYC     = INIT_US * CLK_MHZ;
    localparam int          ACC_CYC      = 2;
    localparam int          CNT_W        = 12;
endpackage : psc_pkg

/* verilog/psc_access.sv */
// Single asynchronous access engine: one read or write on the memory pins.
// Assumes ACC_CYC clock cycles of 50 ns satisfy the device access times.
`timescale 1ns/1ns
module psc_access
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Request
    input  wire logic              i_go,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    // Pins
    output logic                   o_ce_n,
    output logic                   o_we_n,
    output logic                   o_oe_n,
    output logic [ADDR_W-1:0]      o_a,
    output logic [DATA_W-1:0]      o_dq_o,
    output logic                   o_dq_oe,
    input  wire logic [DATA_W-1:0] i_dq_i
);
    logic [CNT_W-1:0] cnt_q;
    logic             busy_q;
    logic             we_q;

    // Every access raises chip select again, so no page read ever happens
    always_ff @(posedge i_clk) begin // R17
        if (!i_rst_n) begin
            busy_q  <= 1'b0;
            cnt_q   <= '0;
            we_q    <= 1'b0;
            o_a     <= '0;
            o_dq_o  <= '0;
            o_rdata <= '0;
        end else if (!busy_q && i_go) begin
            busy_q <= 1'b1;
            cnt_q  <= CNT_W'(ACC_CYC);
            we_q   <= i_we;
            o_a    <= i_addr;
            o_dq_o <= i_wdata;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q == 1) begin
                busy_q <= 1'b0;
                if (!we_q)
                    o_rdata <= i_dq_i;
            end
        end
    end

    // Data latched on rising edge of chip select and write strobe together
    assign o_ce_n  = !busy_q;
    assign o_we_n  = !(busy_q && we_q);
    assign o_oe_n  = !(busy_q && !we_q);
    assign o_dq_oe = busy_q && we_q;
    assign o_done  = busy_q && (cnt_q == 1);
endmodule : psc_access

/* verilog/psc_ctrl.sv */
// Host-side controller for sleep and configuration of an async PSRAM.
// Assumes software on a plain strobe port; read data one cycle later.
`timescale 1ns/1ns
module psc_ctrl
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic              I_CLK_SYS,
    input  wire logic              I_RST_N,
    // Register port
    input  wire logic [3:0]        I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic [31:0]            O_RDATA,
    // Memory pins
    output logic                   O_CE_N,
    output logic                   O_WE_N,
    output logic                   O_OE_N,
    output logic                   O_UPPER_BYTE_ENABLE_N,
    output logic                   O_LOWER_BYTE_ENABLE_N,
    output logic                   O_SLEEP_REQUEST_PIN_N,
    output logic [ADDR_W-1:0]      O_A,
    output logic [DATA_W-1:0]      O_DQ_O,
    output logic                   O_DQ_OE,
    input  wire logic [DATA_W-1:0] I_DQ_I
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_ZFALL = 7'b0000010,
        ST_ZWR   = 7'b0000100,
        ST_SW    = 7'b0001000,
        ST_SLEEP = 7'b0010000,
        ST_INIT  = 7'b0100000,
        ST_SETUP = 7'b1000000
    } psc_state_t;

    function automatic logic [ADDR_W-1:0] psc_clean(input logic [31:0] v);
        psc_clean = v[ADDR_W-1:0] & CFG_WR_MASK;
    endfunction : psc_clean

    // Deep sleep changes only by pin load, so sw loads carry the device's bit
    function automatic logic [ADDR_W-1:0] psc_keep(input logic [ADDR_W-1:0] v,
                                                   input logic [ADDR_W-1:0] d);
        psc_keep                = v;
        psc_keep[CFG_SLEEP_BIT] = d[CFG_SLEEP_BIT];
    endfunction : psc_keep

    psc_state_t        state_q;
    logic [ADDR_W-1:0] cfg_q;
    logic [ADDR_W-1:0] dev_cfg_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [1:0]        step_q;
    logic              sw_rd_q;
    logic              sw_used_q;
    logic              in_sleep_q;
    logic              data_lost_q;
    logic [DATA_W-1:0] rdback_q;
    logic              go;
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic              cmd;
    logic [ADDR_W-1:0] keep_cfg;
    logic [DATA_W-1:0] wdata;
    logic              rd_pend_q;

    assign cmd      = I_WR && (I_ADDR == REG_CTRL) && (state_q == ST_IDLE);
    assign keep_cfg = psc_keep(cfg_q, dev_cfg_q); // R9

    // Staged word, reserved bits cleared; no temperature sensor, so software
    // must pick a refresh level at or above the case temperature
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N)
            cfg_q <= CFG_RESET; // R13
        else if (I_WR && I_ADDR == REG_CFG)
            cfg_q <= psc_clean(I_WDATA); // R1 R12
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            state_q     <= ST_IDLE;
            cnt_q       <= '0;
            step_q      <= '0;
            sw_rd_q     <= 1'b0;
            sw_used_q   <= 1'b0;
            in_sleep_q  <= 1'b0;
            data_lost_q <= 1'b0;
            dev_cfg_q   <= CFG_RESET; // R13
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd && I_WDATA[CTRL_SLEEP]) begin
                        state_q <= ST_SETUP;
                        cnt_q   <= CNT_W'(SLEEP_CYC);
                    end else if (cmd && I_WDATA[CTRL_PINLOAD]) begin
                        state_q <= ST_ZFALL;
                    end else if (cmd && (I_WDATA[CTRL_SWLOAD] || I_WDATA[CTRL_SWREAD])) begin
                        state_q <= ST_SW;
                        step_q  <= '0;
                        sw_rd_q <= I_WDATA[CTRL_SWREAD];
                    end
                end
                ST_ZFALL: state_q <= ST_ZWR;
                ST_ZWR: if (done) begin
                    dev_cfg_q <= cfg_q; // R18
                    state_q   <= ST_IDLE;
                end
                ST_SW: if (done) begin
                    step_q <= step_q + 1'b1;
                    if (step_q == 2'd3) begin
                        state_q <= ST_IDLE;
                        if (!sw_rd_q) begin
                            dev_cfg_q <= keep_cfg; // R9
                            sw_used_q <= 1'b1; // R8
                        end
                    end
                end
                ST_SETUP: begin
                    if (cnt_q != 0)
                        cnt_q <= cnt_q - 1'b1;
                    else
                        in_sleep_q <= 1'b1; // R16
                    // Leave on a control write with the sleep bit clear
                    if (I_WR && I_ADDR == REG_CTRL && !I_WDATA[CTRL_SLEEP])
                        state_q <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    in_sleep_q <= 1'b0;
                    // Deep sleep wipes the array and needs the init wait
                    if (in_sleep_q && !dev_cfg_q[CFG_SLEEP_BIT]) begin // R7
                        data_lost_q <= 1'b1; // R10
                        cnt_q       <= CNT_W'(INIT_CYC);
                        state_q     <= ST_INIT;
                    end else
                        state_q <= ST_IDLE;
                end
                ST_INIT: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (cnt_q == 1)
                        state_q <= ST_IDLE; // R11
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Sleep pin held low through setup, load and sleep
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N)
            O_SLEEP_REQUEST_PIN_N <= 1'b1;
        else
            O_SLEEP_REQUEST_PIN_N <= !(state_q == ST_ZFALL || state_q == ST_ZWR
                                       || state_q == ST_SETUP); // R14
    end

    always_comb begin
        go   = 1'b0;
        we   = 1'b0;
        addr = TOP_ADDR; // R15
        wdata = cfg_q[DATA_W-1:0];
        case (state_q)
            ST_ZWR: begin
                go   = 1'b1;
                we   = 1'b1;
                addr = cfg_q; // R14
            end
            ST_SW: begin
                go = 1'b1;
                we = step_q[1] && !(sw_rd_q && step_q == 2'd3); // R15
                wdata = keep_cfg[DATA_W-1:0]; // R9
            end
            default: ;
        endcase
    end

    psc_access u_access (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RST_N),
        .i_go    (go),
        .i_we    (we),
        .i_addr  (addr),
        .i_wdata (wdata),
        .o_done  (done),
        .o_rdata (rdata),
        .o_ce_n  (O_CE_N),
        .o_we_n  (O_WE_N),
        .o_oe_n  (O_OE_N),
        .o_a     (O_A),
        .o_dq_o  (O_DQ_O),
        .o_dq_oe (O_DQ_OE),
        .i_dq_i  (I_DQ_I)
    );

    // Engine read data lands on the done edge, so take it one cycle later
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            rd_pend_q <= 1'b0;
            rdback_q  <= '0;
        end else begin
            rd_pend_q <= (state_q == ST_SW) && done && (step_q == 2'd3) && sw_rd_q;
            if (rd_pend_q)
                rdback_q <= rdata; // R15
        end
    end

    // Byte enables are don't-care for the pin load; keep both active
    assign O_UPPER_BYTE_ENABLE_N = 1'b0;
    assign O_LOWER_BYTE_ENABLE_N = 1'b0;

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N)
            O_RDATA <= '0;
        else if (I_RD) begin
            case (I_ADDR)
                REG_CFG:    O_RDATA <= {10'h000, cfg_q};
                REG_STATUS: O_RDATA <= {24'h000000, state_q == ST_IDLE, sw_used_q,
                                        in_sleep_q, state_q == ST_INIT, data_lost_q,
                                        dev_cfg_q[CFG_SLEEP_BIT],
                                        dev_cfg_q[CFG_PAGE_BIT],
                                        dev_cfg_q[CFG_EXT_LSB+2:CFG_EXT_LSB] == EXT_NONE};
                REG_RDBACK: O_RDATA <= {16'h0000, rdback_q};
                default:    O_RDATA <= 32'h00000000;
            endcase
        end else
            O_RDATA <= 32'h00000000;
    end
endmodule : psc_ctrl

/* tb/psc_ctrl_sva.sv */
// Pin-level checker for the sleep/configuration host controller.
// Assumes binding to psc_ctrl; sees only its ports.
`timescale 1ns/1ns
module psc_ctrl_sva
    import psc_pkg::*;
(
    input wire logic              I_CLK_SYS,
    input wire logic              I_RST_N,
    input wire logic              O_CE_N,
    input wire logic              O_WE_N,
    input wire logic              O_OE_N,
    input wire logic              O_DQ_OE,
    input wire logic              O_UPPER_BYTE_ENABLE_N,
    input wire logic              O_LOWER_BYTE_ENABLE_N,
    input wire logic              O_SLEEP_REQUEST_PIN_N,
    input wire logic [ADDR_W-1:0] O_A,
    input wire logic [DATA_W-1:0] O_DQ_O
);
    logic             ce_q;
    logic             deep_q;
    logic [1:0]       acc_q;
    logic [CNT_W-1:0] low_q;
    logic [CNT_W-1:0] init_q;
    wire              start = ce_q && !O_CE_N;
    wire              sw    = O_SLEEP_REQUEST_PIN_N;
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            ce_q   <= 1'b1;
            deep_q <= 1'b0;
            acc_q  <= 2'h0;
            low_q  <= '0;
            init_q <= '0;
        end else begin
            ce_q  <= O_CE_N;
            acc_q <= acc_q + 2'(start && sw);
            if (start && !sw && !O_WE_N) deep_q <= !O_A[4];
            low_q <= sw ? '0 : low_q + CNT_W'(low_q != '1);
            // One cycle of slack for the registered pin rise
            if (sw && low_q > SLEEP_CYC && deep_q) init_q <= CNT_W'(INIT_CYC - 1);
            else if (init_q != '0) init_q <= init_q - 1'b1;
        end
    end
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    AST_RSV_PIN: assert property ((!O_CE_N && !O_WE_N && !sw) |->
        (O_A[21:8] == 14'h0 && !O_A[3])) else $error("reserved bit in pin load");
    AST_RSV_SW: assert property ((start && sw && acc_q == 2'h3 && !O_WE_N) |->
        (O_DQ_O[15:8] == 8'h00 && !O_DQ_O[3])) else $error("reserved bit in sw load");
    AST_TOP: assert property (!O_CE_N && sw |-> O_A == TOP_ADDR)
        else $error("sw access off top address");
    AST_ORDER: assert property ((start && sw && acc_q != 2'h3) |->
        (O_WE_N == (acc_q < 2'h2))) else $error("sw sequence order wrong");
    AST_DEEP_KEEP: assert property ((start && sw && acc_q == 2'h3 && !O_WE_N) |->
        O_DQ_O[4] == !deep_q) else $error("sw load changed sleep bit");
    AST_HOLD: assert property (start |=> $stable(O_A) && $stable(O_DQ_O))
        else $error("address or data moved in access");
    AST_SLEEP: assert property (!sw && low_q > 4 |-> O_CE_N)
        else $error("access while sleep pin low");
    AST_INIT: assert property (init_q != '0 |-> O_CE_N)
        else $error("access during init wait");
    AST_DRIVE: assert property (O_DQ_OE == (!O_CE_N && !O_WE_N))
        else $error("data bus drive wrong");
    AST_STROBES: assert property (!O_CE_N |-> (O_OE_N != O_WE_N) &&
        !O_UPPER_BYTE_ENABLE_N && !O_LOWER_BYTE_ENABLE_N) else $error("strobes wrong in access");
endmodule : psc_ctrl_sva
bind psc_ctrl psc_ctrl_sva u_psc_ctrl_sva (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .O_CE_N(O_CE_N), .O_WE_N(O_WE_N),
    .O_OE_N(O_OE_N), .O_DQ_OE(O_DQ_OE),
    .O_UPPER_BYTE_ENABLE_N(O_UPPER_BYTE_ENABLE_N),
    .O_LOWER_BYTE_ENABLE_N(O_LOWER_BYTE_ENABLE_N),
    .O_SLEEP_REQUEST_PIN_N(O_SLEEP_REQUEST_PIN_N), .O_A(O_A), .O_DQ_O(O_DQ_O));

/* tb/psc_mem_model.sv */
// Behavioural PSRAM model: configuration word, sleep modes, sw sequence.
// Assumes host pins held steady through each access.
`timescale 1ns/1ns
module psc_mem_model
    import psc_pkg::*;
(
    input  wire logic              ce_n,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic              sleep_n,
    input  wire logic [ADDR_W-1:0] a,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic [DATA_W-1:0]      dq_o,
    output logic [ADDR_W-1:0]      cfg,
    output logic                   lost,
    output logic                   sw_used,
    output int                     viol
);
    logic [DATA_W-1:0] top_q = 16'h5a3c;
    logic [1:0]        n     = 2'h0;
    logic              arm   = 1'b0;
    logic              wr;
    logic [ADDR_W-1:0] a_l;
    logic [DATA_W-1:0] d_l;
    time               t_fall = 0;
    time               t_init = 0;
    initial begin
        cfg = CFG_RESET;
        lost = 1'b0;
        sw_used = 1'b0;
        viol = 0;
    end
    // Released bus shows the inverse so stale data never matches
    assign dq_o = (!ce_n && !oe_n) ? ((n == 2'h3) ? cfg[15:0] : top_q) : ~top_q;
    always @(negedge sleep_n) begin
        t_fall = $time;
        arm = 1'b1;
    end
    always @(posedge sleep_n) begin
        if ($time - t_fall > 10000 && !cfg[4]) begin
            lost = 1'b1;
            t_init = $time + 150000;
        end
        if ($time - t_fall > 10000 && cfg[4] && !sw_used && cfg[2:0] == EXT_NONE)
            lost = 1'b1;
    end
    always @(negedge ce_n) begin
        #1;
        wr = !we_n;
        a_l = a;
        d_l = dq_i;
        if ((!sleep_n && $time - t_fall > 10000) || $time < t_init) viol++;
    end
    always @(posedge ce_n) begin
        if (wr && arm) cfg = a_l;
        else if (a_l == TOP_ADDR) begin
            if (n == 2'h3 && wr) begin
                cfg[15:0] = d_l;
                sw_used = 1'b1;
            end
            n = ((n < 2'h2 && wr) || (n == 2'h2 && !wr)) ? 2'h0 : n + 2'h1;
        end
        arm = 1'b0;
    end
endmodule : psc_mem_model

/* tb/psc_ctrl_test.sv */
// Register-level testbench for psc_ctrl with a PSRAM model on its pins.
// Assumes a 20 MHz clock and the design's register map.
`timescale 1ns/1ns
module psc_ctrl_test
    import psc_pkg::*;
;
    logic              I_CLK_SYS, I_RST_N, I_WR, I_RD, ce_n, we_n, oe_n, sleep_n, lost, sw_used;
    logic [3:0]        I_ADDR;
    logic [31:0]       I_WDATA, O_RDATA, s;
    logic [ADDR_W-1:0] a, cfg;
    logic [DATA_W-1:0] dq_o, dq_i;
    int                mismatches = 0, checks_done = 0, viol;
    logic [21:0]       tbl [4] = '{22'h3fffff, 22'h000084, 22'h000030, 22'h00004c};
    psc_ctrl u_psc_ctrl (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CE_N(ce_n),
        .O_WE_N(we_n), .O_OE_N(oe_n), .O_UPPER_BYTE_ENABLE_N(), .O_LOWER_BYTE_ENABLE_N(),
        .O_SLEEP_REQUEST_PIN_N(sleep_n), .O_A(a), .O_DQ_O(dq_o), .O_DQ_OE(), .I_DQ_I(dq_i));
    psc_mem_model u_psc_mem_model (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .sleep_n(sleep_n),
        .a(a), .dq_i(dq_o), .dq_o(dq_i), .cfg(cfg), .lost(lost), .sw_used(sw_used), .viol(viol));
    initial begin
        I_CLK_SYS = 1'b0;
        forever #25 I_CLK_SYS = ~I_CLK_SYS;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge I_CLK_SYS);
        I_WR <= 1'b1;
        I_ADDR <= ad;
        I_WDATA <= d;
        @(posedge I_CLK_SYS);
        I_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad);
        @(posedge I_CLK_SYS);
        I_RD <= 1'b1;
        I_ADDR <= ad;
        @(posedge I_CLK_SYS);
        I_RD <= 1'b0;
        @(negedge I_CLK_SYS);
        s = O_RDATA;
    endtask : rd
    task automatic rc(input logic [3:0] ad, input logic [31:0] e, input string nm);
        rd(ad);
        chk(nm, e, s);
    endtask : rc
    // Polls idle; a bounded loop so a stuck engine ends the run
    task automatic idle();
        for (int i = 0; i < 4000; i++) begin
            rd(REG_STATUS);
            if (s[7] === 1'b1) return;
        end
        mismatches++;
        $display("ERROR idle wait timed out");
        summarize();
    endtask : idle
    task automatic pin_load(input logic [31:0] v);
        wr(REG_CFG, v);
        wr(REG_CTRL, 32'h2);
        idle();
    endtask : pin_load
    initial begin
        {I_RST_N, I_WR, I_RD, I_ADDR, I_WDATA} = '0;
        repeat (4) @(posedge I_CLK_SYS);
        I_RST_N <= 1'b1;
        rc(REG_CFG, 32'h70, "cfg reset");
        rc(REG_STATUS, 32'h84, "status reset");
        rc(4'hf, 32'h0, "unmapped read");
        chk("model cfg reset", 32'h70, cfg);
        $display("test reset done");
        foreach (tbl[i]) begin
            wr(REG_CFG, tbl[i]);
            rc(REG_CFG, tbl[i] & 22'hf7, "cfg staged");
            pin_load(tbl[i]);
            chk("cfg loaded", tbl[i] & 22'hf7, cfg);
            rc(REG_STATUS, {24'h0, 1'b1, 4'h0, tbl[i][4], tbl[i][7], tbl[i][2:0] == 3'h4},
                "status");
        end
        $display("test pin loads done");
        wr(REG_CTRL, 32'h1);
        repeat (SLEEP_CYC + 20) @(posedge I_CLK_SYS);
        rd(REG_STATUS);
        chk("in sleep", 32'h1, s[5]);
        wr(REG_CTRL, 32'h0);
        rd(REG_STATUS);
        chk("init wait and lost", 32'h3, s[4:3]);
        idle();
        chk("model data lost", 32'h1, lost);
        chk("access in sleep or init", 32'h0, viol);
        $display("test deep sleep done");
        pin_load(32'h30);
        wr(REG_CFG, 32'h85);
        wr(REG_CTRL, 32'h4);
        idle();
        chk("sw loaded cfg", 32'h95, cfg);
        chk("model sw used", 32'h1, sw_used);
        rd(REG_STATUS);
        chk("status sw used", 32'h1, s[6]);
        wr(REG_CTRL, 32'h8);
        idle();
        rc(REG_RDBACK, 32'h95, "sw readback");
        $display("test sw sequence done");
        wr(REG_CTRL, 32'h1);
        repeat (SLEEP_CYC + 20) @(posedge I_CLK_SYS);
        wr(REG_CTRL, 32'h0);
        rd(REG_STATUS);
        chk("partial exit no init", 32'h0, s[4]);
        chk("partial exit idle", 32'h1, s[7]);
        $display("test partial sleep done");
        summarize();
    end
endmodule : psc_ctrl_test
